// ### accel_event_status.sv
// event flags, orientation status and axis output registers
// assumes the serial slave logic outside gives byte register strobes
// and holds transferActive high for the whole transfer
`timescale 1ns/1ps
`default_nettype none
module accel_event_status import accel_event_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port from the serial slave
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    input wire logic transferActive,
    output logic [7:0] regRdata,
    // measurement front end
    input wire logic sampleValid,
    input wire logic [11:0] xSample,
    input wire logic [11:0] ySample,
    input wire logic [11:0] zSample,
    input wire logic [7:0] tempSample,
    input wire logic [3:0] shakeHit,
    input wire logic otpLoaded,
    // soft reset state
    output logic softResetActive
);
    soft_reset_state_type srState_q;
    soft_reset_state_type srState_d;
    logic [7:0] evA_q;
    logic ready_q;
    logic [1:0] planarInst_q;
    logic [1:0] vertInst_q;
    logic calLoaded_q;
    logic [11:0] x_accel_value_q;
    logic [11:0] y_accel_value_q;
    logic [11:0] z_accel_value_q;
    logic [7:0] tempOut_q;
    logic [7:0] detection_q;
    logic [7:0] rdata_q;
    logic [3:0] filtered;
    logic planarChanged;
    logic verticalChanged;

    // magnitude of a 12-bit two's complement sample; -2048 gives 2048
    function automatic logic [11:0] magnitude(input logic [11:0] v);
        magnitude = v[11] ? 12'(~v + 12'h001) : v;
    endfunction

    // register strobes
    wire logic writeA = regWrite && (regAddr == ADDR_EVENT_A);
    wire logic writeB = regWrite && (regAddr == ADDR_EVENT_B);
    wire logic writeDet = regWrite && (regAddr == ADDR_DETECTION);
    wire logic softClear = (srState_q == SR_HOLD);

    // soft reset: held while the requesting transfer is still running
    always_comb begin
        srState_d = srState_q;
        unique case (srState_q)
            SR_IDLE: begin
                if (writeB && regWdata[CLRB_SOFT_RESET_BIT]) begin
                    srState_d = SR_HOLD;
                end
            end
            SR_HOLD: begin
                if (!transferActive) begin
                    srState_d = SR_IDLE;
                end
            end
            default: srState_d = SR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            srState_q <= SR_IDLE;
        end else begin
            srState_q <= srState_d;
        end
    end

    // orientation of the current reading
    wire logic [11:0] xMag = magnitude(xSample);
    wire logic [11:0] yMag = magnitude(ySample);
    wire logic xDominant = xMag >= yMag;
    wire logic [11:0] maxMag = xDominant ? xMag : yMag;
    wire logic tiltNow = !(maxMag > ORIENT_THRESH);
    wire logic [1:0] planarNow = xDominant ?
        {xSample[11], 1'b0} : {ySample[11], 1'b1};
    wire logic [1:0] planarNext = tiltNow ? planarInst_q : planarNow;

    // unfiltered fields, refreshed on each reading
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            planarInst_q <= 2'b00;
            vertInst_q <= 2'b00;
        end else if (softClear) begin
            planarInst_q <= 2'b00;
            vertInst_q <= 2'b00;
        end else if (sampleValid) begin
            planarInst_q <= planarNext;
            vertInst_q <= {tiltNow, zSample[11]};
        end
    end

    // the filter sees the same fields the reading just produced
    orient_debounce u_debounce (
        .clk(clk),
        .reset_n(reset_n),
        .clear(softClear),
        .step(sampleValid),
        .candidate({tiltNow, zSample[11], planarNext}),
        .countSel(detection_q[1:0]),
        .filtered(filtered),
        .planarChanged(planarChanged),
        .verticalChanged(verticalChanged)
    );

    // event register a: hardware sets, a 1 written clears, set wins except on a set shake bit, whose hit is blocked while its axis is flagged
    wire logic busyX = evA_q[0] || evA_q[1];
    wire logic busyY = evA_q[2] || evA_q[3];
    wire logic [3:0] shakeSet = shakeHit & ~{busyY, busyY, busyX, busyX};
    wire logic [7:0] setA = {verticalChanged, planarChanged, 2'b00,
        shakeSet};
    wire logic [7:0] clrA = writeA ? regWdata : 8'h00;
    wire logic [7:0] evA_d = ((evA_q & ~clrA) | setA) & EVA_USED_MASK;
    wire logic clrReady = writeB && regWdata[EVB_READY_BIT];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evA_q <= 8'h00;
            ready_q <= 1'b0;
        end else if (softClear) begin
            evA_q <= 8'h00;
            ready_q <= 1'b0;
        end else begin
            evA_q <= evA_d;
            ready_q <= sampleValid || (ready_q && !clrReady);
        end
    end

    // outputs latched together so high and low bytes match
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            x_accel_value_q <= 12'h000;
            y_accel_value_q <= 12'h000;
            z_accel_value_q <= 12'h000;
            tempOut_q <= 8'h00;
        end else if (softClear) begin
            x_accel_value_q <= 12'h000;
            y_accel_value_q <= 12'h000;
            z_accel_value_q <= 12'h000;
            tempOut_q <= 8'h00;
        end else if (sampleValid) begin
            x_accel_value_q <= xSample;
            y_accel_value_q <= ySample;
            z_accel_value_q <= zSample;
            tempOut_q <= tempSample;
        end
    end

    // calibration flag survives soft reset; nothing the user writes clears it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            calLoaded_q <= 1'b0;
            detection_q <= DETECTION_RESET;
        end else begin
            calLoaded_q <= calLoaded_q || otpLoaded;
            if (softClear) begin
                detection_q <= DETECTION_RESET;
            end else if (writeDet) begin
                detection_q <= regWdata;
            end
        end
    end

    // read selection; clear registers are write only, so reads see status
    logic [7:0] readMux;
    always_comb begin
        unique case (regAddr)
            ADDR_EVENT_A: readMux = evA_q;
            ADDR_EVENT_B: readMux = {filtered, 3'b000, ready_q};
            ADDR_STATUS_NOW: readMux = {3'b000, calLoaded_q, vertInst_q,
                planarInst_q};
            ADDR_X_HIGH: readMux = x_accel_value_q[11:4];
            ADDR_X_LOW: readMux = {x_accel_value_q[3:0], 4'h0};
            ADDR_Y_HIGH: readMux = y_accel_value_q[11:4];
            ADDR_Y_LOW: readMux = {y_accel_value_q[3:0], 4'h0};
            ADDR_Z_HIGH: readMux = z_accel_value_q[11:4];
            ADDR_Z_LOW: readMux = {z_accel_value_q[3:0], 4'h0};
            ADDR_TEMP: readMux = tempOut_q;
            ADDR_DETECTION: readMux = detection_q;
            default: readMux = 8'h00;
        endcase
    end

    // read data registered: valid the cycle after regRead
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= READ_DATA_RESET;
        end else if (regRead) begin
            rdata_q <= readMux;
        end
    end

    assign regRdata = rdata_q;
    assign softResetActive = srState_q[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_shake_set;
        shakeHit[0] && !busyX && !softClear |=> evA_q[0];
    endproperty
    a_shake_set: assert property (p_shake_set)
        else $error("shake +X event not flagged");

    property p_shake_block;
        evA_q[0] && !evA_q[1] |=> !evA_q[1];
    endproperty
    a_shake_block: assert property (p_shake_block)
        else $error("shake -X flagged while X axis busy");

    property p_planar_flag;
        planarChanged && !softClear |=> evA_q[EVA_PLANAR_BIT];
    endproperty
    a_planar_flag: assert property (p_planar_flag)
        else $error("planar change not flagged");

    property p_vert_flag;
        verticalChanged && !softClear |=> evA_q[EVA_VERT_BIT];
    endproperty
    a_vert_flag: assert property (p_vert_flag)
        else $error("vertical change not flagged");

    property p_planar_code;
        sampleValid && !softClear && !tiltNow && xDominant && !xSample[11]
            |=> planarInst_q == 2'b00;
    endproperty
    a_planar_code: assert property (p_planar_code)
        else $error("planar code wrong for +X");

    property p_planar_hold;
        sampleValid && !softClear && tiltNow |=> $stable(planarInst_q);
    endproperty
    a_planar_hold: assert property (p_planar_hold)
        else $error("planar code moved under low amplitude");

    property p_z_sign;
        sampleValid && !softClear && zSample[11]
            |=> vertInst_q == {$past(tiltNow), 1'b1};
    endproperty
    a_z_sign: assert property (p_z_sign)
        else $error("vertical field wrong for negative Z");

    property p_ready;
        sampleValid && !softClear |=> ready_q;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready bit not set after a measurement");

    property p_clear_a;
        writeA && regWdata[EVA_PLANAR_BIT] && !planarChanged
            |=> !evA_q[EVA_PLANAR_BIT];
    endproperty
    a_clear_a: assert property (p_clear_a)
        else $error("planar flag not cleared by write");

    property p_soft_hold;
        softClear && transferActive |=> softClear;
    endproperty
    a_soft_hold: assert property (p_soft_hold)
        else $error("soft reset released during transfer");

    property p_cal_sticky;
        calLoaded_q |=> calLoaded_q;
    endproperty
    a_cal_sticky: assert property (p_cal_sticky)
        else $error("calibration flag cleared");

    property p_low_nibble;
        regRead && regAddr == ADDR_X_LOW |=> regRdata[3:0] == 4'h0;
    endproperty
    a_low_nibble: assert property (p_low_nibble)
        else $error("axis low nibble not zero");

    property p_status_top;
        regRead && regAddr == ADDR_STATUS_NOW |=> regRdata[7:5] == 3'b000;
    endproperty
    a_status_top: assert property (p_status_top)
        else $error("status upper bits not zero");

    c_soft_reset: cover property (softClear ##1 !softClear);
    c_shake: cover property (shakeHit[2] && !busyY);
    c_tilt: cover property (sampleValid && tiltNow);
    c_clear_race: cover property (writeA && regWdata[0] && shakeHit[0]);
endmodule
`default_nettype wire

// ### accel_event_pkg.sv
// constants shared by the event and orientation status logic
// assumes the register port of the serial interface logic sits outside
package accel_event_pkg;

    // register addresses seen through the serial register port
    localparam logic [7:0] ADDR_EVENT_A = 8'h00;
    localparam logic [7:0] ADDR_EVENT_B = 8'h01;
    localparam logic [7:0] ADDR_STATUS_NOW = 8'h02;
    localparam logic [7:0] ADDR_X_HIGH = 8'h03;
    localparam logic [7:0] ADDR_X_LOW = 8'h04;
    localparam logic [7:0] ADDR_Y_HIGH = 8'h05;
    localparam logic [7:0] ADDR_Y_LOW = 8'h06;
    localparam logic [7:0] ADDR_Z_HIGH = 8'h07;
    localparam logic [7:0] ADDR_Z_LOW = 8'h08;
    localparam logic [7:0] ADDR_TEMP = 8'h09;
    localparam logic [7:0] ADDR_DETECTION = 8'h0C;

    // field positions
    localparam int EVA_PLANAR_BIT = 6;
    localparam int EVA_VERT_BIT = 7;
    localparam int EVB_READY_BIT = 0;
    localparam int CLRB_SOFT_RESET_BIT = 4;
    localparam logic [7:0] EVA_USED_MASK = 8'hCF;

    // reset values
    localparam logic [7:0] DETECTION_RESET = 8'h00;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;

    // orientation amplitude limit: 0.375 g at 1024 counts per g
    localparam int SENS_LSB_PER_G = 1024;
    localparam int ORIENT_LIMIT_MILLI_G = 375;
    localparam logic [11:0] ORIENT_THRESH =
        12'(SENS_LSB_PER_G * ORIENT_LIMIT_MILLI_G / 1000);

    // debounce: 16 readings for code 00, doubling per code step
    localparam logic [7:0] ORIENT_BASE_COUNT = 8'h10;

    typedef enum logic [1:0] {
        SR_IDLE = 2'b01,
        SR_HOLD = 2'b10
    } soft_reset_state_type;

endpackage

// ### orient_debounce.sv
// consecutive-reading filter for the orientation fields
// assumes step pulses once per reading, candidate valid with it
`timescale 1ns/1ps
`default_nettype none
module orient_debounce import accel_event_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    // readings
    input wire logic step,
    input wire logic [3:0] candidate,
    input wire logic [1:0] countSel,
    // filtered result
    output logic [3:0] filtered,
    output logic planarChanged,
    output logic verticalChanged
);
    logic [3:0] filt_q;
    logic [3:0] pend_q;
    logic [7:0] cnt_q;
    logic planarChg_q;
    logic vertChg_q;

    // readings needed for the selected count code
    function automatic logic [7:0] readingsNeeded(input logic [1:0] sel);
        readingsNeeded = ORIENT_BASE_COUNT << sel;
    endfunction

    wire logic differs = candidate != filt_q;
    wire logic samePend = candidate == pend_q;
    wire logic [7:0] cntNext = cnt_q + 8'h01;
    wire logic [7:0] need = readingsNeeded(countSel);
    wire logic reached = samePend && (cntNext >= need);
    wire logic commit = step && differs && reached;

    // a new value must win every reading in a row, else count restarts
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_q <= 4'h0;
            pend_q <= 4'h0;
            cnt_q <= 8'h00;
        end else if (clear) begin
            filt_q <= 4'h0;
            pend_q <= 4'h0;
            cnt_q <= 8'h00;
        end else if (step) begin
            if (!differs) begin
                cnt_q <= 8'h00;
            end else if (samePend) begin
                if (reached) begin
                    filt_q <= candidate;
                    cnt_q <= 8'h00;
                end else begin
                    cnt_q <= cntNext;
                end
            end else begin
                pend_q <= candidate;
                cnt_q <= 8'h01;
            end
        end
    end

    // change pulses, one cycle after the commit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            planarChg_q <= 1'b0;
            vertChg_q <= 1'b0;
        end else begin
            planarChg_q <= commit && !clear &&
                (candidate[1:0] != filt_q[1:0]);
            vertChg_q <= commit && !clear &&
                (candidate[3:2] != filt_q[3:2]);
        end
    end

    assign filtered = filt_q;
    assign planarChanged = planarChg_q;
    assign verticalChanged = vertChg_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_filter_step_only;
        !step && !clear |=> $stable(filt_q);
    endproperty
    a_filter_step_only: assert property (p_filter_step_only)
        else $error("filtered orientation moved without a reading");

    property p_count_bounded;
        cnt_q < need || clear;
    endproperty
    a_count_bounded: assert property (p_count_bounded)
        else $error("debounce count passed its limit");

    c_commit: cover property (commit);
endmodule
`default_nettype wire

// ### host_model.sv
// register-port host standing in for the serial master on the far side
// assumes the bench calls access(); all changes land at falling edges
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input wire logic clk,
    // register port towards the block
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWdata,
    output logic transferActive,
    input wire logic [7:0] regRdata
);
    // idle port: no strobe, no transfer
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
        transferActive = 1'b0;
    end

    // one byte inside one transfer; extra keeps the transfer open longer
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [7:0] wdata, input int extra,
                          output logic [7:0] rdata);
        @(negedge clk);
        transferActive = 1'b1;
        regAddr = addr;
        regWrite = wr;
        regRead = !wr;
        regWdata = wdata;
        @(negedge clk);
        rdata = regRdata;
        regWrite = 1'b0;
        regRead = 1'b0;
        // released lines must not keep showing the last value
        regAddr = ~addr;
        regWdata = ~wdata;
        repeat (extra) @(negedge clk);
        transferActive = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the event and orientation status block
// assumes host_model drives the register port at falling edges
`timescale 1ns/1ps
`default_nettype none
module tb import accel_event_pkg::*;;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr, regWdata, regRdata, tempSample;
    logic regWrite, regRead, transferActive, softResetActive;
    logic sampleValid = 1'b0;
    logic [11:0] xSample = 12'h000;
    logic [11:0] ySample = 12'h000;
    logic [11:0] zSample = 12'h000;
    logic [3:0] shakeHit = 4'h0;
    logic otpLoaded = 1'b0;
    int nFail = 0;
    int nTests = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    accel_event_status u_dut (.clk(clk), .reset_n(reset_n),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .transferActive(transferActive),
        .regRdata(regRdata), .sampleValid(sampleValid),
        .xSample(xSample), .ySample(ySample), .zSample(zSample),
        .tempSample(tempSample), .shakeHit(shakeHit),
        .otpLoaded(otpLoaded), .softResetActive(softResetActive));

    host_model u_host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata),
        .transferActive(transferActive), .regRdata(regRdata));

    task automatic reportAndStop();
        if (nFail == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdChk(input logic [7:0] addr, input logic [7:0] mask,
                         input logic [7:0] exp);
        logic [7:0] d;
        u_host.access(1'b0, addr, 8'h00, 0, d);
        check(d & mask, exp);
    endtask

    task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        u_host.access(1'b1, addr, data, 0, d);
    endtask

    // one reading; two idle cycles let outputs and change flags land
    task automatic meas(input logic [11:0] x, input logic [11:0] y,
                        input logic [11:0] z, input logic [7:0] t);
        @(negedge clk);
        sampleValid = 1'b1;
        xSample = x;
        ySample = y;
        zSample = z;
        tempSample = t;
        @(negedge clk);
        sampleValid = 1'b0;
        xSample = ~x;
        ySample = ~y;
        repeat (2) @(negedge clk);
    endtask

    task automatic pulseShake(input logic [3:0] hits);
        @(negedge clk);
        shakeHit = hits;
        @(negedge clk);
        shakeHit = 4'h0;
    endtask

    // power-up values, read-only and unmapped places
    task automatic tReset();
        rdChk(ADDR_STATUS_NOW, 8'hFF, 8'h00);
        rdChk(ADDR_EVENT_A, 8'hFF, 8'h00);
        wrReg(ADDR_STATUS_NOW, 8'hFF);
        rdChk(ADDR_STATUS_NOW, 8'hE0, 8'h00);
        wrReg(ADDR_X_HIGH, 8'hFF);
        rdChk(ADDR_X_HIGH, 8'hFF, 8'h00);
        rdChk(8'h0F, 8'hFF, 8'h00);
    endtask

    // all four planar codes, then the 0.375 g boundary under tilt
    task automatic tOrient();
        logic [11:0] xs [4] = '{12'h1F4, 12'h000, 12'hE0C, 12'h000};
        logic [11:0] ys [4] = '{12'h000, 12'h1F4, 12'h000, 12'hE0C};
        for (int i = 0; i < 4; i++) begin
            meas(xs[i], ys[i], 12'h064, 8'h00);
            rdChk(ADDR_STATUS_NOW, 8'hFF, 8'(i));
        end
        meas(12'h180, 12'h000, 12'hF9C, 8'h00);
        rdChk(ADDR_STATUS_NOW, 8'hFF, 8'h0F);
        meas(12'h181, 12'h000, 12'hF9C, 8'h00);
        rdChk(ADDR_STATUS_NOW, 8'hFF, 8'h04);
    endtask

    // extreme codes split over high and low bytes, then ready flag
    task automatic tAxis();
        meas(12'h7FF, 12'h800, 12'hA5C, 8'h9B);
        rdChk(ADDR_X_HIGH, 8'hFF, 8'h7F);
        rdChk(ADDR_X_LOW, 8'hFF, 8'hF0);
        rdChk(ADDR_Y_HIGH, 8'hFF, 8'h80);
        rdChk(ADDR_Y_LOW, 8'hFF, 8'h00);
        rdChk(ADDR_Z_HIGH, 8'hFF, 8'hA5);
        rdChk(ADDR_Z_LOW, 8'hFF, 8'hC0);
        rdChk(ADDR_TEMP, 8'hFF, 8'h9B);
        rdChk(ADDR_EVENT_B, 8'h01, 8'h01);
        wrReg(ADDR_EVENT_B, 8'h01);
        rdChk(ADDR_EVENT_B, 8'h01, 8'h00);
    endtask

    // shake bits set, cleared per position, and blocked per axis
    task automatic tShake();
        pulseShake(4'hF);
        rdChk(ADDR_EVENT_A, 8'h0F, 8'h0F);
        wrReg(ADDR_EVENT_A, 8'h00);
        rdChk(ADDR_EVENT_A, 8'h0F, 8'h0F);
        wrReg(ADDR_EVENT_A, 8'h01);
        rdChk(ADDR_EVENT_A, 8'h0F, 8'h0E);
        pulseShake(4'h1);
        rdChk(ADDR_EVENT_A, 8'h0F, 8'h0E);
        wrReg(ADDR_EVENT_A, 8'h02);
        pulseShake(4'h1);
        rdChk(ADDR_EVENT_A, 8'h0F, 8'h0D);
        wrReg(ADDR_EVENT_A, 8'h04);
        pulseShake(4'h4);
        rdChk(ADDR_EVENT_A, 8'h0F, 8'h09);
    endtask

    // soft reset held across the transfer; calibration flag survives
    task automatic tSoftReset();
        logic [7:0] d;
        @(negedge clk);
        otpLoaded = 1'b1;
        @(negedge clk);
        otpLoaded = 1'b0;
        rdChk(ADDR_STATUS_NOW, 8'h10, 8'h10);
        wrReg(ADDR_DETECTION, 8'hA2);
        rdChk(ADDR_DETECTION, 8'hFF, 8'hA2);
        fork
            u_host.access(1'b1, ADDR_EVENT_B, 8'h10, 4, d);
            begin
                repeat (3) @(negedge clk);
                check({7'h00, softResetActive}, 8'h01);
            end
        join
        repeat (3) @(negedge clk);
        check({7'h00, softResetActive}, 8'h00);
        rdChk(ADDR_X_HIGH, 8'hFF, 8'h00);
        rdChk(ADDR_EVENT_A, 8'hFF, 8'h00);
        rdChk(ADDR_DETECTION, 8'hFF, 8'h00);
        rdChk(ADDR_STATUS_NOW, 8'h10, 8'h10);
    endtask

    // count code 01 needs 32 readings, code 00 needs 16
    task automatic tDebounce();
        wrReg(ADDR_DETECTION, 8'h01);
        repeat (31) meas(12'h000, 12'h1F4, 12'h064, 8'h00);
        rdChk(ADDR_EVENT_B, 8'hF0, 8'h00);
        rdChk(ADDR_EVENT_A, 8'hC0, 8'h00);
        meas(12'h000, 12'h1F4, 12'h064, 8'h00);
        rdChk(ADDR_EVENT_B, 8'hF0, 8'h10);
        rdChk(ADDR_EVENT_A, 8'hC0, 8'h40);
        wrReg(ADDR_EVENT_A, 8'hC0);
        wrReg(ADDR_DETECTION, 8'h00);
        repeat (15) meas(12'h000, 12'h000, 12'hF9C, 8'h00);
        rdChk(ADDR_EVENT_B, 8'hF0, 8'h10);
        meas(12'h000, 12'h000, 12'hF9C, 8'h00);
        rdChk(ADDR_EVENT_B, 8'hF0, 8'hD0);
        rdChk(ADDR_EVENT_A, 8'hC0, 8'h80);
        // code 10: a tilted reading in the middle restarts the count
        wrReg(ADDR_EVENT_A, 8'hC0);
        wrReg(ADDR_DETECTION, 8'h02);
        repeat (40) meas(12'h1F4, 12'h000, 12'h064, 8'h00);
        meas(12'h000, 12'h000, 12'hF9C, 8'h00);
        repeat (63) meas(12'h1F4, 12'h000, 12'h064, 8'h00);
        rdChk(ADDR_EVENT_B, 8'hF0, 8'hD0);
        meas(12'h1F4, 12'h000, 12'h064, 8'h00);
        rdChk(ADDR_EVENT_B, 8'hF0, 8'h00);
        rdChk(ADDR_EVENT_A, 8'hC0, 8'hC0);
        // code 11 needs 128 readings
        wrReg(ADDR_EVENT_A, 8'hC0);
        wrReg(ADDR_DETECTION, 8'h03);
        repeat (127) meas(12'h000, 12'hE0C, 12'hF9C, 8'h00);
        rdChk(ADDR_EVENT_B, 8'hF0, 8'h00);
        meas(12'h000, 12'hE0C, 12'hF9C, 8'h00);
        rdChk(ADDR_EVENT_B, 8'hF0, 8'h70);
        rdChk(ADDR_EVENT_A, 8'hC0, 8'hC0);
    endtask

    // main sequence
    initial begin
        tempSample = 8'h00;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        tReset();
        tOrient();
        tAxis();
        tShake();
        tSoftReset();
        tDebounce();
        reportAndStop();
    end

    // hang guard, far beyond the longest sequence
    initial begin
        repeat (50000) @(posedge clk);
        nFail++;
        reportAndStop();
    end
endmodule
`default_nettype wire
